// ===== logic/oerfsm_pkg.sv
// package for the output-port error recovery state machine
package oerfsm_pkg;
   localparam int unsigned ACKID_W       = 3;
   localparam int unsigned TMO_US        = 100;
   localparam int unsigned CLK_MHZ       = 25;
   localparam int unsigned TMO_CYC       = TMO_US * CLK_MHZ;
   localparam int unsigned TMO_THRESH    = 1;
   localparam int unsigned TMR_W         = 16;
   localparam logic [3:0]  CNT_W         = 4'h4;

   typedef enum logic [2:0] {
      OERFSM_DISABLED = 3'b000,
      OERFSM_WAIT     = 3'b001,
      OERFSM_STOP     = 3'b010,
      OERFSM_RECOVER  = 3'b011,
      OERFSM_FATAL    = 3'b100
   } oerfsm_state_t;

   // link-response from the attached device
   typedef struct packed {
      logic                 valid;
      logic [ACKID_W-1:0]   ackid;
   } oerfsm_rsp_t;

   // port status flags shown to the rest of the port
   typedef struct packed {
      logic port_ready;
      logic out_err_stopped;
      logic port_error;
   } oerfsm_stat_t;
endpackage

// ===== logic/oerfsm_ctrl.sv
// output-port error recovery state machine
`timescale 1ns/1ps
// Contract
// - reset idles disabled until recovery enabled
// - only output-port errors start stop-output
// - packet-not-accepted symbol is recoverable output error
// - stop-output halts packets, sends a link-request on entry and after each non-fatal timeout
// - stop-output: ready clear, stopped set, errors ignored
// - stay stopped until response or timeout
// - count timeouts against threshold before fatal
// - outstanding returned ackID moves to recover
// - nothing outstanding: next ackID counts valid
// - unknown ackID or final timeout goes fatal
// - retransmit from returned ackID onward
// - retire earlier ackIDs as accepted
// - update scoreboard before restarting output
// - stay in recover until procedure done
// - once retransmission started, back to waiting
// - fatal: clear stopped, set port error, sys error
// - stay fatal until shutdown completes
// - then wait, output port stays off; port_off holds, but a later recovery raises port_ready and clears tx_halt
module oerfsm_ctrl #(
   parameter int unsigned AW        = oerfsm_pkg::ACKID_W,
   parameter int unsigned TMO_LIMIT = oerfsm_pkg::TMO_CYC,
   parameter int unsigned THRESH    = oerfsm_pkg::TMO_THRESH
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_b,
   input  wire logic                      recov_en,
   input  wire logic                      train_done,
   input  wire logic                      out_err,
   input  wire logic                      in_err,
   input  wire logic                      pna_rcvd,
   input  wire logic [oerfsm_pkg::TMR_W-1:0] tmo_period,
   input  wire oerfsm_pkg::oerfsm_rsp_t   link_rsp,
   input  wire logic [AW-1:0]             oldest_ackid,
   input  wire logic [AW-1:0]             next_ackid,
   input  wire logic                      retx_started,
   input  wire logic                      shutdown_done,
   output logic                           send_link_req,
   output logic                           tx_halt,
   output logic                           retire_req,
   output logic [AW-1:0]                  retire_upto,
   output logic                           retx_req,
   output logic [AW-1:0]                  retx_ackid,
   output logic                           sys_error,
   output logic                           port_off,
   output oerfsm_pkg::oerfsm_stat_t       status
);
   import oerfsm_pkg::*;

   // refused at elaboration: the counters below cannot serve these values
   if (AW < 1 || AW > 8) begin : g_bad_aw
      $error("oerfsm_ctrl: AW out of range");
   end
   if (THRESH < 1 || THRESH > 15) begin : g_bad_thresh
      $error("oerfsm_ctrl: THRESH out of range");
   end
   if (TMO_LIMIT < 1 || TMO_LIMIT > (1 << TMR_W)) begin : g_bad_tmo
      $error("oerfsm_ctrl: TMO_LIMIT does not fit the timer");
   end

   ////////////////////////////////////////////////////////////////////////////
   oerfsm_state_t      state_q, state_d;
   logic [TMR_W-1:0]   tmr_q;
   logic [3:0]         tmo_cnt_q;
   logic               tmo_hit;
   logic               rsp_ok;
   logic               err_go;
   logic               upd_done_q;
   logic [AW-1:0]      span_out, span_rsp;

   // modular distance handles ackID wrap
   assign span_out = AW'(next_ackid - oldest_ackid);
   assign span_rsp = AW'(link_rsp.ackid - oldest_ackid);
   assign rsp_ok   = (span_rsp < span_out) || (link_rsp.ackid == next_ackid);
   assign err_go   = out_err | pna_rcvd;
   // a zero period would wrap to the longest wait; treat it as the default
   assign tmo_hit  = (tmo_period == '0) ? (tmr_q >= TMR_W'(TMO_LIMIT - 1)) : (tmr_q >= tmo_period - 1'b1);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         OERFSM_DISABLED: if (recov_en && train_done) state_d = OERFSM_WAIT;
         OERFSM_WAIT: begin
            if (!recov_en) state_d = OERFSM_DISABLED;
            else if (err_go) state_d = OERFSM_STOP;
         end
         OERFSM_STOP: begin
            if (link_rsp.valid) state_d = rsp_ok ? OERFSM_RECOVER : OERFSM_FATAL;
            else if (tmo_hit && (tmo_cnt_q + 4'h1 >= 4'(THRESH))) state_d = OERFSM_FATAL;
         end
         // leave only once the restart flags stand, else they would never be raised
         OERFSM_RECOVER: if (status.port_ready && retx_started) state_d = OERFSM_WAIT;
         OERFSM_FATAL: if (shutdown_done) state_d = OERFSM_WAIT;
         default: state_d = OERFSM_DISABLED;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) state_q <= OERFSM_DISABLED;
      else state_q <= state_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // response timer; restarts and resends link-request on a non-fatal timeout
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tmr_q     <= '0;
         tmo_cnt_q <= '0;
      end else if (state_q != OERFSM_STOP) begin
         tmr_q     <= '0;
         tmo_cnt_q <= '0;
      end else if (tmo_hit) begin
         tmr_q     <= '0;
         tmo_cnt_q <= tmo_cnt_q + 4'h1;
      end else begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) send_link_req <= 1'b0;
      else send_link_req <= ((state_q == OERFSM_WAIT) && (state_d == OERFSM_STOP))
                            || ((state_q == OERFSM_STOP) && (state_d == OERFSM_STOP) && tmo_hit);
   end

   ////////////////////////////////////////////////////////////////////////////
   // scoreboard update pulse first, restart flags two cycles later
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         retire_req  <= 1'b0;
         retire_upto <= '0;
         retx_req    <= 1'b0;
         retx_ackid  <= '0;
         upd_done_q  <= 1'b0;
      end else begin
         retire_req <= (state_q == OERFSM_STOP) && (state_d == OERFSM_RECOVER);
         retx_req   <= (state_q == OERFSM_STOP) && (state_d == OERFSM_RECOVER);
         if ((state_q == OERFSM_STOP) && link_rsp.valid) begin
            retire_upto <= link_rsp.ackid;
            retx_ackid  <= link_rsp.ackid;
         end
         upd_done_q <= (state_q == OERFSM_RECOVER);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         status    <= '0;
         tx_halt   <= 1'b0;
         sys_error <= 1'b0;
         port_off  <= 1'b0;
      end else begin
         unique case (state_d)
            OERFSM_STOP: begin
               status.port_ready      <= 1'b0;
               status.out_err_stopped <= 1'b1;
               tx_halt                <= 1'b1;
            end
            OERFSM_RECOVER: if (upd_done_q) begin
               status.out_err_stopped <= 1'b0;
               status.port_ready      <= 1'b1;
               tx_halt                <= 1'b0;
            end
            OERFSM_FATAL: begin
               status.out_err_stopped <= 1'b0;
               status.port_error      <= 1'b1;
               port_off               <= 1'b1;
            end
            OERFSM_WAIT: if (state_q == OERFSM_DISABLED) begin
               status.port_ready <= !port_off;
               tx_halt           <= port_off;
            end
            default: ;
         endcase
         sys_error <= (state_d == OERFSM_FATAL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_stop_entry_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_WAIT && state_d == OERFSM_STOP) |=> send_link_req && tx_halt)
      else $error("no link-request on stop entry");
   chk_stop_flags: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_STOP) |-> !status.port_ready && status.out_err_stopped)
      else $error("stop-output flags wrong");
   chk_input_err_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_WAIT && recov_en && in_err && !err_go) |=> state_q == OERFSM_WAIT)
      else $error("input error started output recovery");
   chk_bad_ackid_fatal: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_STOP && link_rsp.valid && !rsp_ok) |=> state_q == OERFSM_FATAL)
      else $error("bad ackID not fatal");
   // the retransmit pulse rises with the state, so both are seen on the same edge
   chk_good_ackid_rec: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_STOP && link_rsp.valid && rsp_ok) |=> state_q == OERFSM_RECOVER && retx_req)
      else $error("good ackID not recovered");
   chk_fatal_flags: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(state_q == OERFSM_FATAL) |-> sys_error && status.port_error && !status.out_err_stopped)
      else $error("fatal flags wrong");
   chk_restart_order: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(status.port_ready) && state_q == OERFSM_RECOVER |-> $past(retire_req, 2))
      else $error("restart before scoreboard update");
   chk_disabled_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_DISABLED && !(recov_en && train_done)) |=> state_q == OERFSM_DISABLED)
      else $error("left disabled early");
   chk_fatal_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_FATAL && shutdown_done) |=> state_q == OERFSM_WAIT && port_off)
      else $error("fatal exit wrong");
   chk_stop_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_STOP && !link_rsp.valid && !tmo_hit) |=> state_q == OERFSM_STOP)
      else $error("left stop-output without cause");
   chk_recover_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == OERFSM_RECOVER && !retx_started) |=> state_q == OERFSM_RECOVER)
      else $error("left recover before retransmission");
   cov_recover: cover property (@(posedge clk_sys) disable iff (!rst_b)
      state_q == OERFSM_RECOVER ##[1:20] state_q == OERFSM_WAIT);
   cov_timeout_fatal: cover property (@(posedge clk_sys) disable iff (!rst_b)
      state_q == OERFSM_STOP && tmo_hit ##1 state_q == OERFSM_FATAL);
   cov_pna: cover property (@(posedge clk_sys) disable iff (!rst_b)
      state_q == OERFSM_WAIT && pna_rcvd ##1 state_q == OERFSM_STOP);
   cov_resend: cover property (@(posedge clk_sys) disable iff (!rst_b)
      state_q == OERFSM_STOP && tmo_hit ##1 state_q == OERFSM_STOP && send_link_req);
   cov_recov_off: cover property (@(posedge clk_sys) disable iff (!rst_b)
      state_q == OERFSM_WAIT && !recov_en ##1 state_q == OERFSM_DISABLED);
endmodule

// ===== verif/oerfsm_partner.sv
// model of the attached device input port answering link-requests
`timescale 1ns/1ps
module oerfsm_partner (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_b,
   input  wire logic                          send_link_req,
   input  wire logic                          mute,
   input  wire logic [7:0]                    delay,
   input  wire logic [oerfsm_pkg::ACKID_W-1:0] ack,
   output oerfsm_pkg::oerfsm_rsp_t            link_rsp
);
   import oerfsm_pkg::*;
   logic       armed_q;
   logic [7:0] cnt_q;
   logic       hit;
   assign hit = armed_q && (cnt_q == 8'h00);
   // idle ackid is inverted so a stale value never looks valid
   assign link_rsp = '{valid: hit, ackid: hit ? ack : ~ack};
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
         cnt_q   <= 8'h00;
      end else if (send_link_req && !mute) begin
         armed_q <= 1'b1;
         cnt_q   <= delay;
      end else if (hit) begin
         armed_q <= 1'b0;
      end else if (armed_q) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule

// ===== verif/oerfsm_ctrl_bench.sv
// self-checking bench for the output recovery state machine
`timescale 1ns/1ps
module oerfsm_ctrl_bench;
   import oerfsm_pkg::*;
   logic clk_sys = 0, rst_b = 0, recov_en = 0, train_done = 0, out_err = 0, in_err = 0, pna = 0;
   logic retx_started = 0, shutdown_done = 0, mute = 0, slr, halt, ret_r, retx_r, sys_err, poff;
   logic [2:0] oldest = 0, next = 0, ack = 0, ret_u, retx_a;
   logic [15:0] tmo_p = 16'h0014;
   oerfsm_rsp_t rsp;
   oerfsm_stat_t st;
   int failures = 0, comparisons = 0, cycles = 0, n;
   // two timeouts before fatal so the resend path is exercised
   oerfsm_ctrl #(.TMO_LIMIT(20), .THRESH(2)) oerfsm_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .recov_en(recov_en),
      .train_done(train_done), .out_err(out_err), .in_err(in_err), .pna_rcvd(pna),
      .tmo_period(tmo_p), .link_rsp(rsp), .oldest_ackid(oldest), .next_ackid(next),
      .retx_started(retx_started), .shutdown_done(shutdown_done), .send_link_req(slr),
      .tx_halt(halt), .retire_req(ret_r), .retire_upto(ret_u), .retx_req(retx_r),
      .retx_ackid(retx_a), .sys_error(sys_err), .port_off(poff), .status(st));
   oerfsm_partner oerfsm_partner_i (.clk_sys(clk_sys), .rst_b(rst_b), .send_link_req(slr),
      .mute(mute), .delay(8'h04), .ack(ack), .link_rsp(rsp));
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // pulse an error input for one cycle, return whether a link-request went out
   task automatic hit(input int kind, output logic got);
      @(negedge clk_sys);
      if (kind == 0) out_err = 1; else if (kind == 1) in_err = 1; else pna = 1;
      @(negedge clk_sys);
      got = slr;
      out_err = 0;
      in_err = 0;
      pna = 0;
   endtask
   task automatic t_disabled_and_input();
      logic g;
      hit(0, g);
      check("req_disabled", g, 0);
      train_done = 1;
      recov_en = 1;
      hit(1, g);
      check("req_in_err", g, 0);
      recov_en = 0;
      hit(2, g);
      check("req_recov_off", g, 0);
      recov_en = 1;
   endtask
   task automatic t_recover(input logic [2:0] o, input logic [2:0] nx, input logic [2:0] a);
      logic g;
      oldest = o;
      next = nx;
      ack = a;
      hit(2, g);
      check("req_pna", g, 1);
      check("halt", halt, 1);
      check("stat_stop", st, 3'b010);
      hit(0, g);
      check("req_ignored", g, 0);
      for (n = 0; n < 20 && retx_r !== 1; n++) @(negedge clk_sys);
      check("retx_req", retx_r, 1);
      check("retx_ackid", retx_a, a);
      check("retire_req", ret_r, 1);
      check("retire_upto", ret_u, a);
      check("stat_rec", st, 3'b010);
      retx_started = 1;
      for (n = 0; n < 20 && st.port_ready !== 1; n++) @(negedge clk_sys);
      check("stat_ready", st, 3'b100);
      check("halt_off", halt, 0);
      repeat (2) @(negedge clk_sys);
      retx_started = 0;
   endtask
   task automatic t_fatal(input logic timeout);
      logic g;
      oldest = 3'h2;
      next = 3'h5;
      ack = 3'h6;
      mute = timeout;
      // zero period selects the built-in limit
      tmo_p = timeout ? 16'h0000 : 16'h0014;
      hit(0, g);
      check("req_wait", g, 1);
      if (timeout) begin
         repeat (10) @(negedge clk_sys);
         check("still_stop", sys_err, 0);
         for (n = 0; n < 15 && slr !== 1; n++) @(negedge clk_sys);
         check("resend_req", slr, 1);
      end
      for (n = 0; n < 40 && sys_err !== 1; n++) @(negedge clk_sys);
      check("sys_error", sys_err, 1);
      check("stat_fatal", st, 3'b001);
      repeat (3) @(negedge clk_sys);
      check("stay_fatal", sys_err, 1);
      shutdown_done = 1;
      @(negedge clk_sys);
      shutdown_done = 0;
      repeat (2) @(negedge clk_sys);
      check("sys_err_off", sys_err, 0);
      check("port_off", poff, 1);
      mute = 0;
   endtask
   // mid-run reset clears the sticky shut-off and rearms the port
   task automatic t_reset();
      @(negedge clk_sys);
      rst_b = 0;
      @(negedge clk_sys);
      check("poff_rst", poff, 0);
      check("stat_rst", st, 3'b000);
      check("syserr_rst", sys_err, 0);
      rst_b = 1;
      repeat (2) @(negedge clk_sys);
      check("stat_rearm", st, 3'b100);
      check("halt_rearm", halt, 0);
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      rst_b = 1;
      t_disabled_and_input();
      t_recover(3'h2, 3'h5, 3'h3);
      t_recover(3'h4, 3'h4, 3'h4);
      t_fatal(0);
      t_fatal(1);
      t_reset();
      give_verdict();
   end
endmodule
